// [include/cdps_pkg.sv]
// Shared constants for the clock distribution power and delay control block
package cdps_pkg;

	// Serial control port framing
	localparam int          INSTR_BITS   = 16;
	localparam int          BYTE_BITS    = 8;
	localparam int          ADDR_W       = 13;
	localparam int          INSTR_RW_BIT = 15;
	localparam int          INSTR_W_MSB  = 14;
	localparam int          INSTR_W_LSB  = 13;
	localparam logic [3:0]  INSTR_LAST   = 4'hF;
	localparam logic [3:0]  BYTE_LAST    = 4'h7;

	// Register offsets
	localparam logic [12:0] OFS_PORT_CFG   = 13'h0000;
	localparam logic [12:0] OFS_PLL_PD     = 13'h000A;
	localparam logic [12:0] OFS_RAMP_A     = 13'h0035;
	localparam logic [12:0] OFS_FINE_A     = 13'h0036;
	localparam logic [12:0] OFS_RAMP_B     = 13'h0039;
	localparam logic [12:0] OFS_FINE_B     = 13'h003A;
	localparam logic [12:0] OFS_OUT_PD     = 13'h0044;
	localparam logic [12:0] OFS_OUT_LEVEL  = 13'h0045;
	localparam logic [12:0] OFS_FUNC_DIST  = 13'h0058;
	localparam logic [12:0] OFS_UPDATE     = 13'h005A;

	// Storage indices of the shadowed registers
	localparam int          REG_COUNT      = 9;
	localparam logic [3:0]  IDX_PORT_CFG   = 4'h0;
	localparam logic [3:0]  IDX_PLL_PD     = 4'h1;
	localparam logic [3:0]  IDX_RAMP_A     = 4'h2;
	localparam logic [3:0]  IDX_FINE_A     = 4'h3;
	localparam logic [3:0]  IDX_RAMP_B     = 4'h4;
	localparam logic [3:0]  IDX_FINE_B     = 4'h5;
	localparam logic [3:0]  IDX_OUT_PD     = 4'h6;
	localparam logic [3:0]  IDX_OUT_LEVEL  = 4'h7;
	localparam logic [3:0]  IDX_FUNC_DIST  = 4'h8;
	localparam logic [3:0]  IDX_NONE       = 4'hF;

	// Reset values
	localparam logic [7:0]  REG_RESET      = 8'h00;

	// Field positions
	localparam int          PORT_SDO_EN_BIT = 7;
	localparam int          UPDATE_BIT      = 0;
	localparam int          DIST_PD_BIT     = 3;
	localparam int          FUNC_MSB        = 6;
	localparam int          FUNC_LSB        = 5;
	localparam int          RAMP_MSB        = 2;
	localparam int          RAMP_LSB        = 0;
	localparam int          CAP_MSB         = 5;
	localparam int          CAP_LSB         = 3;
	localparam int          FINE_MSB        = 5;
	localparam int          FINE_LSB        = 1;
	localparam int          PECL_MSB        = 3;
	localparam int          PECL_LSB        = 0;
	localparam int          LVDS_MSB        = 7;
	localparam int          LVDS_LSB        = 4;
	localparam int          PLL_MSB         = 1;
	localparam int          PLL_LSB         = 0;

	// Function pin assignment code for sleep
	localparam logic [1:0]  FUNC_SLEEP      = 2'h2;

	// PLL power-down field codes
	localparam logic [1:0]  PLL_NORMAL_0    = 2'h0;
	localparam logic [1:0]  PLL_ASYNC_PD    = 2'h1;
	localparam logic [1:0]  PLL_NORMAL_1    = 2'h2;
	localparam logic [1:0]  PLL_SYNC_PD     = 2'h3;

	// Serial port phases
	typedef enum logic [0:0] {
		PH_INSTR,
		PH_DATA
	} cdps_phase_t;

endpackage

// [src/cdps_pin_sync.sv]
// Three-stage pin synchroniser with agreement filter
`timescale 1ns/1ps
`default_nettype none

module cdps_pin_sync #(
	parameter logic INIT = 1'b0
) (
	// Clock and reset
	input  wire logic clock_in,
	input  wire logic nrst_in,
	// Pin side
	input  wire logic pin_in,
	// Synchronised level
	output logic      level_out
);

	logic stage1_ff;
	logic stage2_ff;
	logic stage3_ff;

	// Only stage two reads stage one; metastability stays in the chain
	always_ff @(posedge clock_in)
	begin
		if (!nrst_in)
		begin
			stage1_ff <= INIT;
			stage2_ff <= INIT;
			stage3_ff <= INIT;
		end
		else
		begin
			stage1_ff <= pin_in;
			stage2_ff <= stage1_ff;
			stage3_ff <= stage2_ff;
		end
	end

	// A change counts once stages two and three agree
	always_ff @(posedge clock_in)
	begin
		if (!nrst_in)
			level_out <= INIT;
		else if (stage2_ff == stage3_ff)
			level_out <= stage3_ff;
	end

endmodule

`default_nettype wire

// [src/cdps_top.sv]
// Power-down, sleep and delay control of the clock distribution device
`timescale 1ns/1ps
`default_nettype none

module cdps_top (
	// Clock and reset
	input  wire logic       clock_in,
	input  wire logic       nrst_in,
	// Serial control port pins
	input  wire logic       sclk_in,
	input  wire logic       csb_in,
	input  wire logic       sdio_in,
	output logic            sdio_out,
	output logic            sdio_oe_out,
	output logic            sdo_out,
	output logic            sdo_oe_out,
	// Function pin and charge pump
	input  wire logic       chip_sleep_request_in,
	input  wire logic       cp_event_in,
	// Power state
	output logic            sleep_out,
	output logic            pll_power_down_out,
	output logic            clocks_off_out,
	output logic            dividers_off_out,
	output logic            distribution_power_down_out,
	output logic [3:0]      lvpecl_enable_out,
	output logic [3:0]      lvpecl_safe_off_out,
	output logic [3:0]      lvds_cmos_enable_out,
	output logic [3:0]      cmos_select_out,
	// Delay element of delayed_output_a
	output logic [3:0]      delay_a_ramp_units_out,
	output logic [2:0]      delay_a_cap_count_out,
	output logic [4:0]      delay_a_fine_out,
	// Delay element of delayed_output_b
	output logic [3:0]      delay_b_ramp_units_out,
	output logic [2:0]      delay_b_cap_count_out,
	output logic [4:0]      delay_b_fine_out
);

	// Synchronised pin levels
	logic                   sclk_lvl;
	logic                   csb_lvl;
	logic                   sdio_lvl;
	logic                   sleep_pin_lvl;
	logic                   sclk_prev_ff;
	logic                   sclk_rise;
	logic                   sclk_fall;

	// Serial port state
	cdps_pkg::cdps_phase_t  phase_ff;
	logic [3:0]             bit_cnt_ff;
	logic [15:0]            shift_ff;
	logic                   read_ff;
	logic [1:0]             bytes_left_ff;
	logic [12:0]            addr_ff;
	logic [7:0]             rd_shift_ff;
	logic                   wr_en_ff;
	logic [12:0]            wr_addr_ff;
	logic [7:0]             wr_data_ff;
	logic                   update_ff;
	logic [15:0]            instr;
	logic [7:0]             byte_in;
	logic [12:0]            next_addr;

	// Register storage
	logic [7:0]             shadow_ff [cdps_pkg::REG_COUNT];
	logic [7:0]             active_ff [cdps_pkg::REG_COUNT];
	logic                   pll_pd_ff;
	logic                   pll_pend_ff;
	logic                   sleep_ff;
	logic [1:0]             nxt_pll_mode;

	// Maps an address onto a storage index, IDX_NONE when unmapped
	function automatic logic [3:0] reg_index(input logic [12:0] a);
		logic [3:0] idx;
		idx = cdps_pkg::IDX_NONE;
		unique case (a)
			cdps_pkg::OFS_PORT_CFG:  idx = cdps_pkg::IDX_PORT_CFG;
			cdps_pkg::OFS_PLL_PD:    idx = cdps_pkg::IDX_PLL_PD;
			cdps_pkg::OFS_RAMP_A:    idx = cdps_pkg::IDX_RAMP_A;
			cdps_pkg::OFS_FINE_A:    idx = cdps_pkg::IDX_FINE_A;
			cdps_pkg::OFS_RAMP_B:    idx = cdps_pkg::IDX_RAMP_B;
			cdps_pkg::OFS_FINE_B:    idx = cdps_pkg::IDX_FINE_B;
			cdps_pkg::OFS_OUT_PD:    idx = cdps_pkg::IDX_OUT_PD;
			cdps_pkg::OFS_OUT_LEVEL: idx = cdps_pkg::IDX_OUT_LEVEL;
			cdps_pkg::OFS_FUNC_DIST: idx = cdps_pkg::IDX_FUNC_DIST;
			default:                 idx = cdps_pkg::IDX_NONE;
		endcase
		return idx;
	endfunction

	// Readback comes from the shadow copy; unmapped and update read zero
	function automatic logic [7:0] read_byte(input logic [12:0] a);
		logic [3:0] idx;
		idx = reg_index(a);
		if (idx == cdps_pkg::IDX_NONE)
			return cdps_pkg::REG_RESET;
		return shadow_ff[idx];
	endfunction

	// Capacitor count is the number of zero bits plus one
	function automatic logic [2:0] cap_count(input logic [2:0] bits);
		return 3'(1) + 3'(!bits[0]) + 3'(!bits[1]) + 3'(!bits[2]);
	endfunction

	// Ramp current in 200 uA units is the code plus one
	function automatic logic [3:0] ramp_units(input logic [2:0] code);
		return {1'b0, code} + 4'h1;
	endfunction

	// Pin synchronisers
	cdps_pin_sync #(.INIT(1'b0)) u_sync_sclk (
		.clock_in  (clock_in),
		.nrst_in   (nrst_in),
		.pin_in    (sclk_in),
		.level_out (sclk_lvl)
	);

	cdps_pin_sync #(.INIT(1'b1)) u_sync_csb (
		.clock_in  (clock_in),
		.nrst_in   (nrst_in),
		.pin_in    (csb_in),
		.level_out (csb_lvl)
	);

	cdps_pin_sync #(.INIT(1'b0)) u_sync_sdio (
		.clock_in  (clock_in),
		.nrst_in   (nrst_in),
		.pin_in    (sdio_in),
		.level_out (sdio_lvl)
	);

	cdps_pin_sync #(.INIT(1'b1)) u_sync_sleep (
		.clock_in  (clock_in),
		.nrst_in   (nrst_in),
		.pin_in    (chip_sleep_request_in),
		.level_out (sleep_pin_lvl)
	);

	// Serial clock edge detection on the filtered level
	always_ff @(posedge clock_in)
	begin
		if (!nrst_in)
			sclk_prev_ff <= 1'b0;
		else
			sclk_prev_ff <= sclk_lvl;
	end

	assign sclk_rise = sclk_lvl && !sclk_prev_ff && !csb_lvl;
	assign sclk_fall = !sclk_lvl && sclk_prev_ff && !csb_lvl;
	assign instr     = {shift_ff[14:0], sdio_lvl};
	assign byte_in   = {shift_ff[6:0], sdio_lvl};
	// Multibyte transfers walk downward through the map
	assign next_addr = addr_ff - 13'h0001;

	// Serial port framing; runs regardless of sleep
	// port stays active
	always_ff @(posedge clock_in)
	begin
		if (!nrst_in)
		begin
			phase_ff      <= cdps_pkg::PH_INSTR;
			bit_cnt_ff    <= 4'h0;
			shift_ff      <= 16'h0000;
			read_ff       <= 1'b0;
			bytes_left_ff <= 2'h0;
			addr_ff       <= 13'h0000;
			rd_shift_ff   <= 8'h00;
			sdio_out      <= 1'b0;
			sdo_out       <= 1'b0;
		end
		else if (csb_lvl)
		begin
			// Stalling off a byte boundary abandons the transfer
			if (bit_cnt_ff != 4'h0)
			begin
				phase_ff   <= cdps_pkg::PH_INSTR;
				bit_cnt_ff <= 4'h0;
			end
		end
		else if (sclk_rise)
		begin
			shift_ff <= instr;
			if (phase_ff == cdps_pkg::PH_INSTR)
			begin
				bit_cnt_ff <= bit_cnt_ff + 4'h1;
				if (bit_cnt_ff == cdps_pkg::INSTR_LAST)
				begin
					phase_ff      <= cdps_pkg::PH_DATA;
					bit_cnt_ff    <= 4'h0;
					read_ff       <= instr[cdps_pkg::INSTR_RW_BIT];
					bytes_left_ff <= instr[cdps_pkg::INSTR_W_MSB:
						cdps_pkg::INSTR_W_LSB];
					addr_ff       <= instr[cdps_pkg::ADDR_W-1:0];
					rd_shift_ff   <= read_byte(instr[cdps_pkg::ADDR_W-1:0]);
				end
			end
			else
			begin
				bit_cnt_ff <= bit_cnt_ff + 4'h1;
				if (bit_cnt_ff == cdps_pkg::BYTE_LAST)
				begin
					bit_cnt_ff    <= 4'h0;
					addr_ff       <= next_addr;
					bytes_left_ff <= bytes_left_ff - 2'h1;
					rd_shift_ff   <= read_byte(next_addr);
					if (bytes_left_ff == 2'h0)
						phase_ff <= cdps_pkg::PH_INSTR;
				end
			end
		end
		else if (sclk_fall && phase_ff == cdps_pkg::PH_DATA && read_ff)
		begin
			// Read data changes on the falling edge, MSB first
			sdio_out    <= rd_shift_ff[7];
			sdo_out     <= rd_shift_ff[7];
			rd_shift_ff <= {rd_shift_ff[6:0], 1'b0};
		end
	end

	// Pin drive: 3-wire reads use SDIO; in 4-wire mode SDO is driven whenever CSB is low, read or write
	always_ff @(posedge clock_in)
	begin
		if (!nrst_in)
		begin
			sdio_oe_out <= 1'b0;
			sdo_oe_out  <= 1'b0;
		end
		else
		begin
			sdio_oe_out <= !csb_lvl && read_ff
				&& phase_ff == cdps_pkg::PH_DATA
				&& !shadow_ff[cdps_pkg::IDX_PORT_CFG]
					[cdps_pkg::PORT_SDO_EN_BIT];
			sdo_oe_out  <= !csb_lvl
				&& shadow_ff[cdps_pkg::IDX_PORT_CFG]
					[cdps_pkg::PORT_SDO_EN_BIT];
		end
	end

	// One-cycle write strobe per completed data byte
	always_ff @(posedge clock_in)
	begin
		if (!nrst_in)
		begin
			wr_en_ff   <= 1'b0;
			wr_addr_ff <= 13'h0000;
			wr_data_ff <= 8'h00;
		end
		else
		begin
			wr_en_ff   <= !csb_lvl && sclk_rise && !read_ff
				&& phase_ff == cdps_pkg::PH_DATA
				&& bit_cnt_ff == cdps_pkg::BYTE_LAST;
			wr_addr_ff <= addr_ff;
			wr_data_ff <= byte_in;
		end
	end

	// Shadow buffer takes every mapped write; the port config acts at once
	// writes go to shadow
	always_ff @(posedge clock_in)
	begin
		if (!nrst_in)
		begin
			for (int i = 0; i < cdps_pkg::REG_COUNT; i++)
				shadow_ff[i] <= cdps_pkg::REG_RESET;
		end
		else if (wr_en_ff && reg_index(wr_addr_ff) != cdps_pkg::IDX_NONE)
			shadow_ff[reg_index(wr_addr_ff)] <= wr_data_ff;
	end

	// Update bit is a self-clearing strobe; it never stores
	always_ff @(posedge clock_in)
	begin
		if (!nrst_in)
			update_ff <= 1'b0;
		else
			update_ff <= wr_en_ff && wr_addr_ff == cdps_pkg::OFS_UPDATE
				&& wr_data_ff[cdps_pkg::UPDATE_BIT];
	end

	// Active copy moves as a whole so all pending changes land together
	// update transfer
	always_ff @(posedge clock_in)
	begin
		if (!nrst_in)
		begin
			for (int i = 0; i < cdps_pkg::REG_COUNT; i++)
				active_ff[i] <= cdps_pkg::REG_RESET;
		end
		else if (update_ff)
		begin
			for (int i = 0; i < cdps_pkg::REG_COUNT; i++)
				active_ff[i] <= shadow_ff[i];
		end
	end

	// Sleep follows the function pin only while it is assigned to sleep
	// pin low means sleep
	always_ff @(posedge clock_in)
	begin
		if (!nrst_in)
			sleep_ff <= 1'b0;
		else
			sleep_ff <= !sleep_pin_lvl
				&& active_ff[cdps_pkg::IDX_FUNC_DIST]
					[cdps_pkg::FUNC_MSB:cdps_pkg::FUNC_LSB]
					== cdps_pkg::FUNC_SLEEP;
	end

	assign nxt_pll_mode = shadow_ff[cdps_pkg::IDX_PLL_PD]
		[cdps_pkg::PLL_MSB:cdps_pkg::PLL_LSB];

	// PLL power-down modes; the event input comes from same-clock logic
	// mode decode
	always_ff @(posedge clock_in)
	begin
		if (!nrst_in)
		begin
			pll_pd_ff   <= 1'b0;
			pll_pend_ff <= 1'b0;
		end
		else if (update_ff)
		begin
			unique case (nxt_pll_mode)
				cdps_pkg::PLL_ASYNC_PD:
				begin
					pll_pd_ff   <= 1'b1;
					pll_pend_ff <= 1'b0;
				end
				cdps_pkg::PLL_SYNC_PD:
				begin
					pll_pend_ff <= !pll_pd_ff;
				end
				cdps_pkg::PLL_NORMAL_0,
				cdps_pkg::PLL_NORMAL_1:
				begin
					pll_pd_ff   <= 1'b0;
					pll_pend_ff <= 1'b0;
				end
			endcase
		end
		else if (pll_pend_ff && cp_event_in)
		begin
			pll_pd_ff   <= 1'b1;
			pll_pend_ff <= 1'b0;
		end
	end

	// Power outputs; sleep overrides the PLL and output enable modes without altering them
	// sleep shutdown
	always_ff @(posedge clock_in)
	begin
		if (!nrst_in)
		begin
			sleep_out                   <= 1'b0;
			pll_power_down_out          <= 1'b0;
			clocks_off_out              <= 1'b0;
			dividers_off_out            <= 1'b0;
			distribution_power_down_out <= 1'b0;
			lvpecl_enable_out           <= 4'h0;
			lvpecl_safe_off_out         <= 4'h0;
			lvds_cmos_enable_out        <= 4'h0;
			cmos_select_out             <= 4'h0;
		end
		else
		begin
			sleep_out          <= sleep_ff;
			pll_power_down_out <= pll_pd_ff || sleep_ff;
			clocks_off_out     <= sleep_ff;
			dividers_off_out   <= sleep_ff;
			distribution_power_down_out <=
				active_ff[cdps_pkg::IDX_FUNC_DIST][cdps_pkg::DIST_PD_BIT];
			// Safe-off bias is lost once distribution bias is removed
			lvpecl_safe_off_out <= (sleep_ff
				&& !active_ff[cdps_pkg::IDX_FUNC_DIST]
					[cdps_pkg::DIST_PD_BIT]) ? 4'hF : 4'h0;
			lvpecl_enable_out <= sleep_ff ? 4'h0 :
				~active_ff[cdps_pkg::IDX_OUT_PD]
					[cdps_pkg::PECL_MSB:cdps_pkg::PECL_LSB];
			lvds_cmos_enable_out <= sleep_ff ? 4'h0 :
				~active_ff[cdps_pkg::IDX_OUT_PD]
					[cdps_pkg::LVDS_MSB:cdps_pkg::LVDS_LSB];
			cmos_select_out <= active_ff[cdps_pkg::IDX_OUT_LEVEL]
				[cdps_pkg::LVDS_MSB:cdps_pkg::LVDS_LSB];
		end
	end

	// Delay codes come only from the active copy, so one update moves all
	// delay registers
	always_ff @(posedge clock_in)
	begin
		if (!nrst_in)
		begin
			delay_a_ramp_units_out <= 4'h0;
			delay_a_cap_count_out  <= 3'h0;
			delay_a_fine_out       <= 5'h00;
			delay_b_ramp_units_out <= 4'h0;
			delay_b_cap_count_out  <= 3'h0;
			delay_b_fine_out       <= 5'h00;
		end
		else
		begin
			delay_a_ramp_units_out <= ramp_units(active_ff
				[cdps_pkg::IDX_RAMP_A][cdps_pkg::RAMP_MSB:cdps_pkg::RAMP_LSB]);
			delay_b_ramp_units_out <= ramp_units(active_ff
				[cdps_pkg::IDX_RAMP_B][cdps_pkg::RAMP_MSB:cdps_pkg::RAMP_LSB]);
			delay_a_cap_count_out <= cap_count(active_ff
				[cdps_pkg::IDX_RAMP_A][cdps_pkg::CAP_MSB:cdps_pkg::CAP_LSB]);
			delay_b_cap_count_out <= cap_count(active_ff
				[cdps_pkg::IDX_RAMP_B][cdps_pkg::CAP_MSB:cdps_pkg::CAP_LSB]);
			delay_a_fine_out <= active_ff[cdps_pkg::IDX_FINE_A]
				[cdps_pkg::FINE_MSB:cdps_pkg::FINE_LSB];
			delay_b_fine_out <= active_ff[cdps_pkg::IDX_FINE_B]
				[cdps_pkg::FINE_MSB:cdps_pkg::FINE_LSB];
		end
	end

endmodule

`default_nettype wire

// [testbench/cdps_host.sv]
// Host model driving the serial control port and the function pin
`timescale 1ns/1ps
`default_nettype none

module cdps_host (
	// Clock and returned data wire
	input  wire logic clock_in,
	input  wire logic sdio_in,
	// Port and function pins
	output logic      sclk_out,
	output logic      csb_out,
	output logic      sdio_out,
	output logic      sleep_pin_out
);
	// Idle pins: port deselected, function pin high
	initial
	begin
		sclk_out = 1'b0;
		csb_out = 1'b1;
		sdio_out = 1'b0;
		sleep_pin_out = 1'b1;
	end

	// Each sclk level lasts 8 clocks so the slow pin filter sees it;
	// read data is taken just before the rising edge
	task automatic shift(input logic [31:0] v, input int n, input logic rd,
		inout logic [31:0] q);
		for (int i = n - 1; i >= 0; i--)
		begin
			// Released line toggles, so a stale value cannot pass
			sdio_out = rd ? ~sdio_out : v[i];
			repeat (8) @(negedge clock_in);
			q = {q[30:0], sdio_in};
			sclk_out = 1'b1;
			repeat (8) @(negedge clock_in);
			sclk_out = 1'b0;
		end
	endtask

	task automatic xfer(input logic rd, input int nb, input logic [12:0] a,
		input logic [31:0] d, output logic [31:0] q);
		q = 32'h0;
		csb_out = 1'b0;
		repeat (4) @(negedge clock_in);
		shift({16'h0, rd, 2'(nb - 1), a}, 16, 1'b0, q);
		q = 32'h0;
		shift(d, nb * 8, rd, q);
		csb_out = 1'b1;
		repeat (8) @(negedge clock_in);
	endtask
endmodule

`default_nettype wire

// [testbench/cdps_properties.sv]
// Concurrent checks on the power state and serial port pins
`timescale 1ns/1ps
`default_nettype none

module cdps_properties (
	// Clock and reset
	input wire logic       clock_in,
	input wire logic       nrst_in,
	// Pins seen by the block
	input wire logic       csb_in,
	input wire logic       sclk_in,
	input wire logic       chip_sleep_request_in,
	// Read data pins
	input wire logic       sdio_out,
	input wire logic       sdio_oe_out,
	input wire logic       sdo_oe_out,
	// Power state
	input wire logic       sleep_out,
	input wire logic       pll_power_down_out,
	input wire logic       clocks_off_out,
	input wire logic       dividers_off_out,
	input wire logic       distribution_power_down_out,
	input wire logic [3:0] lvpecl_enable_out,
	input wire logic [3:0] lvpecl_safe_off_out,
	input wire logic [3:0] lvds_cmos_enable_out
);
	default clocking cb @(posedge clock_in);
	endclocking
	default disable iff (!nrst_in);

	// Held states; three cycles of sleep or distribution lets registered outputs catch up
	sequence held_sleep;
		sleep_out[*3];
	endsequence
	sequence held_dist;
		distribution_power_down_out[*3];
	endsequence
	sequence port_idle;
		csb_in[*6];
	endsequence
	sequence sclk_high;
		(sclk_in && !csb_in)[*8];
	endsequence

	sleep_pll_a: assert property (held_sleep |-> pll_power_down_out)
		else $error("PLL running while asleep");
	sleep_clock_a: assert property (held_sleep |-> clocks_off_out &&
		dividers_off_out) else $error("Clocks running while asleep");
	sleep_outputs_a: assert property (held_sleep |->
		(lvpecl_enable_out | lvds_cmos_enable_out) == 4'h0)
		else $error("Output enabled while asleep");
	sleep_safe_a: assert property ((sleep_out &&
		!distribution_power_down_out)[*3] |-> lvpecl_safe_off_out == 4'hF)
		else $error("Safe-off missing while asleep");
	dist_safe_a: assert property (held_dist |->
		lvpecl_safe_off_out == 4'h0) else $error("Safe-off with bias removed");
	pin_wake_a: assert property (chip_sleep_request_in[*8] |->
		!sleep_out) else $error("Asleep with function pin high");
	idle_port_a: assert property (port_idle |->
		!sdio_oe_out && !sdo_oe_out) else $error("Data pin driven while idle");
	read_hold_a: assert property (sclk_high |-> $stable(sdio_out))
		else $error("Read bit changed while sclk high");
	one_driver_a: assert property (!(sdio_oe_out && sdo_oe_out))
		else $error("Both data pins driven at once");
endmodule

`default_nettype wire

// [testbench/clock_dist_power_and_delay_ctrl_bench.sv]
// Self-checking bench with a register model of the control block
`timescale 1ns/1ps
`default_nettype none

module clock_dist_power_and_delay_ctrl_bench;
	// Clock, reset, pump, pins and design outputs
	logic        clk, nrst, cp, sclk, csb, hsdio, pin, wsdio, rdat;
	logic        so, soe, sdo, sdo_oe, slp, pll, ckoff, dvoff, dpd;
	logic [3:0]  pe, ps, le, cs, ar, br;
	logic [2:0]  ac, bc;
	logic [4:0]  af, bf;
	// Register model: shadow and active copies
	logic [7:0]  sv [0:127];
	logic [7:0]  av [0:127];
	logic [31:0] seed, q;
	logic        cp_hit;
	int          miscompares, n_checks;

	// Three-wire data line: the design wins while it drives
	assign wsdio = soe ? so : hsdio;
	// Host reads the separate data pin only while the design drives it
	assign rdat = sdo_oe ? sdo : wsdio;

	cdps_top dut (.clock_in(clk), .nrst_in(nrst), .sclk_in(sclk),
		.csb_in(csb), .sdio_in(wsdio), .sdio_out(so), .sdio_oe_out(soe),
		.sdo_out(sdo), .sdo_oe_out(sdo_oe), .chip_sleep_request_in(pin),
		.cp_event_in(cp), .sleep_out(slp), .pll_power_down_out(pll),
		.clocks_off_out(ckoff), .dividers_off_out(dvoff),
		.distribution_power_down_out(dpd), .lvpecl_enable_out(pe),
		.lvpecl_safe_off_out(ps), .lvds_cmos_enable_out(le),
		.cmos_select_out(cs), .delay_a_ramp_units_out(ar),
		.delay_a_cap_count_out(ac), .delay_a_fine_out(af),
		.delay_b_ramp_units_out(br), .delay_b_cap_count_out(bc),
		.delay_b_fine_out(bf));
	cdps_host host (.clock_in(clk), .sdio_in(rdat), .sclk_out(sclk),
		.csb_out(csb), .sdio_out(hsdio), .sleep_pin_out(pin));

	// 25 MHz clock
	initial
	begin
		clk = 1'b0;
		forever #20 clk = ~clk;
	end

	// Xorshift stimulus source
	function automatic logic [31:0] rnd();
		seed = seed ^ (seed << 13);
		seed = seed ^ (seed >> 17);
		seed = seed ^ (seed << 5);
		return seed;
	endfunction

	function automatic logic [11:0] dly(input logic [7:0] rr, ff);
		return {{1'b0, rr[2:0]} + 4'h1, 3'h4 - 3'($countones(rr[5:3])),
			ff[5:1]};
	endfunction

	function automatic logic mapped(input logic [7:0] a);
		return a inside {8'h00, 8'h0A, 8'h35, 8'h36, 8'h39, 8'h3A, 8'h44,
			8'h45, 8'h58};
	endfunction

	task automatic chk(input string nm, input logic [15:0] e, g);
		n_checks++;
		if (g !== e)
		begin
			miscompares++;
			$display("CHECK FAILED %s expected %h seen %h", nm, e, g);
		end
	endtask

	task automatic end_sim();
		if (miscompares == 0 && n_checks > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask

	// Write frame; unmapped bytes are dropped, update copies shadow
	task automatic wr(input logic [7:0] a, input int nb, input logic [31:0] d);
		logic [7:0] b;
		host.xfer(1'b0, nb, {5'h00, a}, d, q);
		for (int k = 0; k < nb; k++)
		begin
			b = d[8 * (nb - 1 - k) +: 8];
			if (mapped(a - 8'(k)))
				sv[a - 8'(k)] = b;
			if (a - 8'(k) == 8'h5A && b[0])
			begin
				av = sv;
				cp_hit = 1'b0;
			end
		end
	endtask

	// Read frame, compared with the shadow copy
	task automatic rdc(input logic [7:0] a, input int nb);
		host.xfer(1'b1, nb, {5'h00, a}, 32'h0, q);
		for (int k = 0; k < nb; k++)
			chk("readback", {8'h00, mapped(a - 8'(k)) ? sv[a - 8'(k)] : 8'h00},
				{8'h00, q[8 * (nb - 1 - k) +: 8]});
	endtask

	// Every control output against the active copy
	task automatic check_all();
		logic s, d, p;
		s = av[8'h58][6:5] == 2'h2 && !pin;
		d = av[8'h58][3];
		p = s | av[8'h0A][1:0] == 2'h1 | cp_hit;
		chk("power", {12'h0, s, p, s, s}, {12'h0, slp, pll, ckoff, dvoff});
		chk("outputs", {8'h00, s ? 8'h00 : ~av[8'h44]}, {8'h00, le, pe});
		chk("cmos", {12'h0, av[8'h45][7:4]}, {12'h0, cs});
		chk("dist", {11'h0, d, (s && !d) ? 4'hF : 4'h0}, {11'h0, dpd, ps});
		chk("delay a", {4'h0, dly(av[8'h35], av[8'h36])},
			{4'h0, ar, ac, af});
		chk("delay b", {4'h0, dly(av[8'h39], av[8'h3A])},
			{4'h0, br, bc, bf});
	endtask

	// Hang guard
	initial
	begin
		repeat (90000) @(posedge clk);
		miscompares++;
		end_sim();
	end

	initial
	begin
		seed = 32'h24;
		miscompares = 0;
		n_checks = 0;
		cp_hit = 1'b0;
		cp = 1'b0;
		nrst = 1'b0;
		foreach (sv[j])
			sv[j] = 8'h00;
		av = sv;
		repeat (6) @(negedge clk);
		nrst = 1'b1;
		repeat (4) @(negedge clk);
		// Reset values, unmapped bytes, self-clearing update bit
		chk("reset", 16'h0, {13'h0, slp, pll, dpd});
		rdc(8'h0A, 4);
		wr(8'h5A, 1, 32'h1);
		rdc(8'h5A, 2);
		check_all();
		// Random delay and output codes; nothing moves before update
		for (int i = 0; i < 8; i++)
		begin
			wr(8'h3A, 4, rnd());
			wr(8'h36, 2, rnd());
			wr(8'h45, 2, rnd());
			check_all();
			rdc(8'h3A, 4);
			wr(8'h5A, 1, 32'h1);
			check_all();
		end
		// All power-down codes; a pump event only matters in code 11
		for (int m = 0; m < 4; m++)
		begin
			wr(8'h0A, 1, 32'(m));
			wr(8'h5A, 1, 32'h1);
			check_all();
			cp = 1'b1;
			@(negedge clk);
			cp = 1'b0;
			cp_hit = m == 3;
			repeat (4) @(negedge clk);
			check_all();
		end
		// Low pin is harmless until sleep is assigned to it
		host.sleep_pin_out = 1'b0;
		repeat (10) @(negedge clk);
		check_all();
		wr(8'h0A, 1, 32'h0);
		wr(8'h58, 1, 32'h40);
		wr(8'h5A, 1, 32'h1);
		check_all();
		rdc(8'h36, 2);
		host.sleep_pin_out = 1'b1;
		repeat (10) @(negedge clk);
		check_all();
		// Distribution off: sleep no longer keeps the safe-off bias
		wr(8'h58, 1, 32'h48);
		wr(8'h5A, 1, 32'h1);
		check_all();
		host.sleep_pin_out = 1'b0;
		repeat (10) @(negedge clk);
		check_all();
		host.sleep_pin_out = 1'b1;
		repeat (10) @(negedge clk);
		check_all();
		// Four-wire mode: read data comes back on the separate pin
		wr(8'h00, 1, 32'h80);
		rdc(8'h39, 2);
		// Mid-run reset restores defaults and three-wire mode
		nrst = 1'b0;
		repeat (6) @(negedge clk);
		nrst = 1'b1;
		foreach (sv[j])
			sv[j] = 8'h00;
		av = sv;
		cp_hit = 1'b0;
		repeat (4) @(negedge clk);
		check_all();
		rdc(8'h00, 2);
		end_sim();
	end
endmodule

bind cdps_top cdps_properties chk (.clock_in, .nrst_in, .csb_in, .sclk_in,
	.chip_sleep_request_in, .sdio_out, .sdio_oe_out, .sdo_oe_out,
	.sleep_out, .pll_power_down_out, .clocks_off_out, .dividers_off_out,
	.distribution_power_down_out, .lvpecl_enable_out, .lvpecl_safe_off_out,
	.lvds_cmos_enable_out);

`default_nettype wire
